// ---- core/ahbm_pkg.sv ----
// Shared constants, types and decode helpers of the multilayer bus matrix.
package ahbm_pkg;

	// ------------------------------------------------------------
	// Port counts and widths
	// ------------------------------------------------------------
	localparam int NM = 5;
	localparam int NS = 7;
	localparam int AW = 32;
	localparam int DW = 32;
	localparam int MW = 3;
	localparam int SW = 3;
	localparam int PAGE_LSB = 10;
	localparam int PW = AW - PAGE_LSB;

	// ------------------------------------------------------------
	// Master and slave port indices
	// ------------------------------------------------------------
	localparam logic [MW-1:0] M_IFETCH = 3'h0;
	localparam logic [MW-1:0] M_CDATA = 3'h1;
	localparam logic [MW-1:0] M_CSYS = 3'h2;
	localparam logic [MW-1:0] M_DMA_A = 3'h3;
	localparam logic [MW-1:0] M_DMA_B = 3'h4;
	localparam logic [SW-1:0] S_FLASH_I = 3'h0;
	localparam logic [SW-1:0] S_FLASH_D = 3'h1;
	localparam logic [SW-1:0] S_SRAM = 3'h2;
	localparam logic [SW-1:0] S_EXTMEM = 3'h3;
	localparam logic [SW-1:0] S_AHBP = 3'h4;
	localparam logic [SW-1:0] S_PLOW = 3'h5;
	localparam logic [SW-1:0] S_PHIGH = 3'h6;
	localparam logic [SW-1:0] S_NONE = 3'h7;

	// Row per slave, bit per master (bit 0 is the instruction fetch master).
	localparam logic [NS-1:0][NM-1:0] CONN_MAP = {
		5'h1c, 5'h1c, 5'h1c, 5'h1f, 5'h1f, 5'h1a, 5'h01
	};

	// ------------------------------------------------------------
	// Address regions
	// ------------------------------------------------------------
	localparam logic [AW-1:0] CODE_BASE = 32'h0000_0000;
	localparam logic [AW-1:0] CODE_LAST = 32'h1fff_ffff;
	localparam logic [AW-1:0] SRAM_BASE = 32'h2000_0000;
	localparam logic [AW-1:0] SRAM_LAST = 32'h3fff_ffff;
	localparam logic [AW-1:0] PLOW_BASE = 32'h4000_0000;
	localparam logic [AW-1:0] PLOW_LAST = 32'h4000_ffff;
	localparam logic [AW-1:0] PHIGH_BASE = 32'h4001_0000;
	localparam logic [AW-1:0] PHIGH_LAST = 32'h4001_ffff;
	localparam logic [AW-1:0] AHBP_BASE = 32'h4002_0000;
	localparam logic [AW-1:0] AHBP_LAST = 32'h5fff_ffff;
	localparam logic [AW-1:0] EXT_BASE = 32'h6000_0000;
	localparam logic [AW-1:0] EXT_LAST = 32'h6fff_ffff;

	// ------------------------------------------------------------
	// Bus encodings, reset values and clock rates
	// ------------------------------------------------------------
	localparam logic [1:0] HT_IDLE = 2'h0;
	localparam logic [1:0] HT_NONSEQ = 2'h2;
	localparam logic [MW-1:0] ARB_LAST_RST = 3'h4;
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int PLOW_MAX_HZ = 54_000_000;
	localparam int PHIGH_MAX_HZ = 108_000_000;

	typedef enum logic [2:0] {
		MS_IDLE = 3'h0,
		MS_WAIT = 3'h1,
		MS_DATA = 3'h2,
		MS_DONE = 3'h3,
		MS_ERR1 = 3'h4,
		MS_ERR2 = 3'h5
	} ahbm_mst_t;

	typedef enum logic [1:0] {
		SS_IDLE = 2'h0,
		SS_ADDR = 2'h1,
		SS_DATA = 2'h2
	} ahbm_slv_t;

	function automatic int ahbm_pdiv(input int max_hz);
		return (SYS_CLK_HZ + max_hz - 1) / max_hz;
	endfunction

	localparam int PLOW_DIV = ahbm_pdiv(PLOW_MAX_HZ);
	localparam int PHIGH_DIV = ahbm_pdiv(PHIGH_MAX_HZ);
	localparam logic [1:0][3:0] PDIV_LAST = {4'(PHIGH_DIV - 1), 4'(PLOW_DIV - 1)};

	function automatic logic ahbm_in_rng(input logic [PW-1:0] pg, input logic [AW-1:0] lo,
		input logic [AW-1:0] hi);
		return (pg >= lo[AW-1:PAGE_LSB]) && (pg <= hi[AW-1:PAGE_LSB]);
	endfunction

	// Maps a master's address to its slave port, or S_NONE where no path exists.
	function automatic logic [SW-1:0] ahbm_decode(input logic [MW-1:0] mi,
		input logic [AW-1:0] a);
		logic [PW-1:0] pg;
		logic [SW-1:0] s;
		pg = a[AW-1:PAGE_LSB];
		if (ahbm_in_rng(pg, CODE_BASE, CODE_LAST)) begin
			s = (mi == M_IFETCH) ? S_FLASH_I : S_FLASH_D;
		end else if (ahbm_in_rng(pg, SRAM_BASE, SRAM_LAST)) begin
			s = S_SRAM;
		end else if (ahbm_in_rng(pg, PLOW_BASE, PLOW_LAST)) begin
			s = S_PLOW;
		end else if (ahbm_in_rng(pg, PHIGH_BASE, PHIGH_LAST)) begin
			s = S_PHIGH;
		end else if (ahbm_in_rng(pg, AHBP_BASE, AHBP_LAST)) begin
			s = S_AHBP;
		end else if (ahbm_in_rng(pg, EXT_BASE, EXT_LAST)) begin
			s = S_EXTMEM;
		end else begin
			s = S_NONE;
		end
		if (s != S_NONE && !CONN_MAP[s][mi]) begin
			s = S_NONE;
		end
		return s;
	endfunction

	function automatic logic [MW-1:0] ahbm_oh2idx(input logic [NM-1:0] oh);
		logic [MW-1:0] idx;
		idx = '0;
		for (int i = 0; i < NM; i++) begin
			if (oh[i]) begin
				idx = MW'(i);
			end
		end
		return idx;
	endfunction

endpackage

// ---- core/ahbm_rr_arb.sv ----
// Round-robin arbiter for one slave port of the bus matrix.
`timescale 1ns/1ps
module ahbm_rr_arb import ahbm_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Requests and grant
	input wire logic en,
	input wire logic [NM-1:0] req,
	output logic [NM-1:0] gnt
);

	logic [MW-1:0] last_ff;

	// Search starts just after the last winner so no master starves.
	always_comb begin
		int j;
		logic found;
		j = 0;
		found = 1'b0;
		gnt = '0;
		for (int k = 1; k <= NM; k++) begin
			j = (int'(last_ff) + k) % NM;
			if (en && !found && req[j]) begin
				gnt[j] = 1'b1;
				found = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			last_ff <= ARB_LAST_RST;
		end else if (|gnt) begin
			last_ff <= ahbm_oh2idx(gnt);
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_gnt_onehot: assert property ($onehot0(gnt)) else $error("more than one grant");
	chk_gnt_has_req: assert property ((|gnt) |-> (gnt & req) == gnt) else $error("grant without request");

endmodule

// ---- core/ahbm_matrix.sv ----
// Multilayer AHB interconnect matrix: five masters, seven slave ports.
`timescale 1ns/1ps

// Operation
// - 32-bit fabric; each slave port runs on its own so paths work in parallel.
// - Matrix feeds one AHB peripheral bus and two APB bridges as slave ports.
// - Five master ports: fetch, core data, core system, two DMA masters.
// - Seven slave ports: flash instr, flash data, SRAM, ext mem, AHB, two APB.
// - Fixed connectivity map decides which master reaches which slave.
// - Unconnected master and slave pairs have no path at all.
// - System regions routed for the system master are SRAM, external memory and peripherals.
// - Each DMA master port belongs to exactly one DMA controller.
// - Flash instruction slave is the flash controller's instruction side.
// - Flash data slave is the flash controller's data side.
// - AHB peripheral port forwards onto a bus reaching every AHB peripheral.
// - Low peripheral bus clock never exceeds 54 MHz.
// - High peripheral bus runs at full system clock, up to 108 MHz.
// - Peripherals decode on 1 KB windows, ignoring the low ten address bits.
// - Addresses 0x6000_0000 to 0x6fff_ffff go to the external memory slave.
module ahbm_matrix import ahbm_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Master ports
	input wire logic [NM-1:0][AW-1:0] m_haddr,
	input wire logic [NM-1:0][1:0] m_htrans,
	input wire logic [NM-1:0] m_hwrite,
	input wire logic [NM-1:0][2:0] m_hsize,
	input wire logic [NM-1:0][3:0] m_hprot,
	input wire logic [NM-1:0][DW-1:0] m_hwdata,
	output logic [NM-1:0] m_hready,
	output logic [NM-1:0] m_hresp,
	output logic [NM-1:0][DW-1:0] m_hrdata,
	// Slave ports
	output logic [NS-1:0] s_hsel,
	output logic [NS-1:0][AW-1:0] s_haddr,
	output logic [NS-1:0][1:0] s_htrans,
	output logic [NS-1:0] s_hwrite,
	output logic [NS-1:0][2:0] s_hsize,
	output logic [NS-1:0][3:0] s_hprot,
	output logic [NS-1:0][DW-1:0] s_hwdata,
	output logic [NS-1:0] s_hready,
	input wire logic [NS-1:0] s_hreadyout,
	input wire logic [NS-1:0] s_hresp,
	input wire logic [NS-1:0][DW-1:0] s_hrdata,
	// Peripheral bus clock enables
	output logic plow_pclk_en,
	output logic phigh_pclk_en
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	ahbm_mst_t mst_ff [NM];
	ahbm_mst_t nxt_mst [NM];
	logic [NM-1:0][AW-1:0] hold_addr_ff;
	logic [NM-1:0] hold_write_ff;
	logic [NM-1:0][2:0] hold_size_ff;
	logic [NM-1:0][3:0] hold_prot_ff;
	logic [NM-1:0][SW-1:0] tgt_ff;
	logic [NM-1:0][DW-1:0] rdata_ff;
	logic [NM-1:0] take_req;
	logic [NM-1:0][SW-1:0] dec_slv;
	logic [NM-1:0] mst_gnt;
	logic [NM-1:0] mst_done;
	logic [NM-1:0] mst_err;
	logic [NM-1:0][DW-1:0] done_data;
	ahbm_slv_t sst_ff [NS];
	logic [NS-1:0][MW-1:0] own_ff;
	logic [NS-1:0][NM-1:0] slv_req;
	logic [NS-1:0][NM-1:0] slv_gnt;
	logic [NS-1:0] slv_idle;
	logic [NS-1:0] slv_done;
	logic [NS-1:0] hsel_ff;
	logic [NS-1:0][AW-1:0] haddr_ff;
	logic [NS-1:0] hwrite_ff;
	logic [NS-1:0][2:0] hsize_ff;
	logic [NS-1:0][3:0] hprot_ff;
	logic [NS-1:0][DW-1:0] hwdata_ff;
	logic [1:0][3:0] pdiv_ff;

	// ------------------------------------------------------------
	// Master side
	// ------------------------------------------------------------
	// A master's address phase is held here until its slave grants it.
	always_comb begin
		for (int m = 0; m < NM; m++) begin
			m_hready[m] = mst_ff[m] inside {MS_IDLE, MS_DONE, MS_ERR2};
			m_hresp[m] = mst_ff[m] inside {MS_ERR1, MS_ERR2};
			take_req[m] = m_hready[m] && m_htrans[m][1];
			dec_slv[m] = ahbm_decode(MW'(m), m_haddr[m]);
		end
	end

	always_comb begin
		mst_gnt = '0;
		mst_done = '0;
		mst_err = '0;
		done_data = '0;
		for (int s = 0; s < NS; s++) begin
			mst_gnt = mst_gnt | slv_gnt[s];
			if (slv_done[s]) begin
				mst_done[own_ff[s]] = 1'b1;
				mst_err[own_ff[s]] = s_hresp[s];
				done_data[own_ff[s]] = s_hrdata[s];
			end
		end
	end

	always_comb begin
		for (int m = 0; m < NM; m++) begin
			nxt_mst[m] = mst_ff[m];
			case (mst_ff[m])
				MS_IDLE, MS_DONE, MS_ERR2: begin
					if (take_req[m]) begin
						nxt_mst[m] = (dec_slv[m] == S_NONE) ? MS_ERR1 : MS_WAIT;
					end else begin
						nxt_mst[m] = MS_IDLE;
					end
				end
				MS_WAIT: begin
					if (mst_gnt[m]) begin
						nxt_mst[m] = MS_DATA;
					end
				end
				MS_DATA: begin
					if (mst_done[m]) begin
						nxt_mst[m] = mst_err[m] ? MS_ERR1 : MS_DONE;
					end
				end
				MS_ERR1: nxt_mst[m] = MS_ERR2;
				default: nxt_mst[m] = MS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int m = 0; m < NM; m++) begin
				mst_ff[m] <= MS_IDLE;
			end
		end else begin
			for (int m = 0; m < NM; m++) begin
				mst_ff[m] <= nxt_mst[m];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hold_addr_ff <= '0;
			hold_write_ff <= '0;
			hold_size_ff <= '0;
			hold_prot_ff <= '0;
			tgt_ff <= '0;
		end else begin
			for (int m = 0; m < NM; m++) begin
				if (take_req[m]) begin
					hold_addr_ff[m] <= m_haddr[m];
					hold_write_ff[m] <= m_hwrite[m];
					hold_size_ff[m] <= m_hsize[m];
					hold_prot_ff[m] <= m_hprot[m];
					tgt_ff[m] <= dec_slv[m];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_ff <= '0;
		end else begin
			for (int m = 0; m < NM; m++) begin
				if (mst_done[m]) begin
					rdata_ff[m] <= done_data[m];
				end
			end
		end
	end

	assign m_hrdata = rdata_ff;

	// ------------------------------------------------------------
	// Slave side
	// ------------------------------------------------------------
	// Every slave port has its own arbiter and sequencer, so masters bound
	// for different slaves proceed in the same cycles.
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			slv_idle[s] = sst_ff[s] == SS_IDLE;
			slv_done[s] = (sst_ff[s] == SS_DATA) && s_hreadyout[s];
			s_hready[s] = (sst_ff[s] == SS_DATA) ? s_hreadyout[s] : 1'b1;
			for (int m = 0; m < NM; m++) begin
				slv_req[s][m] = (mst_ff[m] == MS_WAIT) && (tgt_ff[m] == SW'(s)) && CONN_MAP[s][m];
			end
		end
	end

	for (genvar s = 0; s < NS; s++) begin : g_slv
		ahbm_rr_arb u_arb (
			.clk_sys(clk_sys),
			.rst(rst),
			.en(slv_idle[s]),
			.req(slv_req[s]),
			.gnt(slv_gnt[s])
		);
	end

	// Address phase is issued from flops one cycle after the grant; write data
	// is taken from the owner while it is held in its stalled data phase.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int s = 0; s < NS; s++) begin
				sst_ff[s] <= SS_IDLE;
			end
			own_ff <= '0;
			hsel_ff <= '0;
			haddr_ff <= '0;
			hwrite_ff <= '0;
			hsize_ff <= '0;
			hprot_ff <= '0;
			hwdata_ff <= '0;
		end else begin
			for (int s = 0; s < NS; s++) begin
				case (sst_ff[s])
					SS_IDLE: begin
						if (|slv_gnt[s]) begin
							own_ff[s] <= ahbm_oh2idx(slv_gnt[s]);
							hsel_ff[s] <= 1'b1;
							haddr_ff[s] <= hold_addr_ff[ahbm_oh2idx(slv_gnt[s])];
							hwrite_ff[s] <= hold_write_ff[ahbm_oh2idx(slv_gnt[s])];
							hsize_ff[s] <= hold_size_ff[ahbm_oh2idx(slv_gnt[s])];
							hprot_ff[s] <= hold_prot_ff[ahbm_oh2idx(slv_gnt[s])];
							sst_ff[s] <= SS_ADDR;
						end
					end
					SS_ADDR: begin
						hsel_ff[s] <= 1'b0;
						hwdata_ff[s] <= m_hwdata[own_ff[s]];
						sst_ff[s] <= SS_DATA;
					end
					SS_DATA: begin
						if (s_hreadyout[s]) begin
							sst_ff[s] <= SS_IDLE;
						end
					end
					default: sst_ff[s] <= SS_IDLE;
				endcase
			end
		end
	end

	assign s_hsel = hsel_ff;
	assign s_haddr = haddr_ff;
	assign s_hwrite = hwrite_ff;
	assign s_hsize = hsize_ff;
	assign s_hprot = hprot_ff;
	assign s_hwdata = hwdata_ff;
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			s_htrans[s] = hsel_ff[s] ? HT_NONSEQ : HT_IDLE;
		end
	end

	// ------------------------------------------------------------
	// Peripheral bus clock enables
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pdiv_ff <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				pdiv_ff[i] <= (pdiv_ff[i] == PDIV_LAST[i]) ? 4'h0 : pdiv_ff[i] + 4'h1;
			end
		end
	end

	assign plow_pclk_en = pdiv_ff[0] == 4'h0;
	assign phigh_pclk_en = pdiv_ff[1] == 4'h0;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	for (genvar s = 0; s < NS; s++) begin : g_chk_s
		chk_path_allowed: assert property (s_hsel[s] |-> CONN_MAP[s][own_ff[s]])
			else $error("slave selected by unconnected master");
		chk_slave_seq: assert property ((|slv_gnt[s]) |=> s_hsel[s] ##1 (!s_hsel[s] && sst_ff[s] == SS_DATA))
			else $error("slave address phase out of order");
		chk_done_return: assert property ((slv_done[s] && !s_hresp[s]) |=> (m_hready[own_ff[s]] && !m_hresp[own_ff[s]]))
			else $error("completed transfer not returned to owner");
	end

	for (genvar m = 0; m < NM; m++) begin : g_chk_m
		chk_illegal_error: assert property ((take_req[m] && dec_slv[m] == S_NONE) |=> (m_hresp[m] && !m_hready[m]) ##1 (m_hresp[m] && m_hready[m]))
			else $error("illegal access lacks two-cycle error");
		chk_page_decode: assert property (take_req[m] |-> ahbm_decode(MW'(m), m_haddr[m] ^ 32'h0000_03ff) == dec_slv[m])
			else $error("decode depends on low ten address bits");
		chk_ext_route: assert property ((take_req[m] && m_haddr[m][31:28] == 4'h6) |-> dec_slv[m] == S_EXTMEM)
			else $error("external RAM region misrouted");
	end

	chk_code_fetch: assert property ((take_req[0] && m_haddr[0][31:29] == 3'h0) |-> dec_slv[0] == S_FLASH_I)
		else $error("fetch of code region not sent to flash instruction port");
	chk_code_data: assert property ((take_req[1] && m_haddr[1][31:29] == 3'h0) |-> dec_slv[1] == S_FLASH_D)
		else $error("data access of code region not sent to flash data port");
	chk_plow_rate: assert property (plow_pclk_en |-> ##1 (PLOW_DIV == 1 || !plow_pclk_en))
		else $error("low peripheral clock enable too frequent");

	cov_contention: cover property ($countones(slv_req[S_SRAM]) > 1);
	cov_parallel: cover property (s_hsel[S_EXTMEM] && s_hsel[S_FLASH_I]);
	cov_illegal: cover property (take_req[M_IFETCH] && dec_slv[M_IFETCH] == S_NONE);
	cov_slave_error: cover property (slv_done[S_SRAM] && s_hresp[S_SRAM]);

endmodule

// ---- test/ahbm_slave_model.sv ----
// Behavioural slave ports that answer the matrix, with wait states and errors on request.
`timescale 1ns/1ps
module ahbm_slave_model import ahbm_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Slave side of the matrix
	input wire logic [NS-1:0] s_hsel,
	input wire logic [NS-1:0][AW-1:0] s_haddr,
	input wire logic [NS-1:0] s_hwrite,
	input wire logic [NS-1:0][DW-1:0] s_hwdata,
	input wire logic [NS-1:0] s_hready,
	output logic [NS-1:0] s_hreadyout,
	output logic [NS-1:0] s_hresp,
	output logic [NS-1:0][DW-1:0] s_hrdata,
	// Test control and observation
	input wire logic [3:0] wait_cnt,
	input wire logic [NS-1:0] err_en,
	output logic [NS-1:0][7:0] hits,
	output logic [NS-1:0][DW-1:0] last_wdata
);
	logic [NS-1:0] act_ff;
	logic [NS-1:0] err2_ff;
	logic [NS-1:0] wr_ff;
	logic [NS-1:0][3:0] cnt_ff;
	logic [NS-1:0][AW-1:0] adr_ff;
	logic [NS-1:0] fin;

	// A transfer is taken only while the port is selected and ready is high.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			act_ff <= '0;
			err2_ff <= '0;
			wr_ff <= '0;
			cnt_ff <= '0;
			adr_ff <= '0;
			hits <= '0;
			last_wdata <= '0;
		end else begin
			for (int s = 0; s < NS; s++) begin
				if (!act_ff[s]) begin
					if (s_hsel[s] && s_hready[s]) begin
						act_ff[s] <= 1'b1;
						cnt_ff[s] <= wait_cnt;
						adr_ff[s] <= s_haddr[s];
						wr_ff[s] <= s_hwrite[s];
						hits[s] <= hits[s] + 8'h01;
					end
				end else if (cnt_ff[s] != 4'h0) begin
					cnt_ff[s] <= cnt_ff[s] - 4'h1;
				end else if (err_en[s] && !err2_ff[s]) begin
					err2_ff[s] <= 1'b1;
				end else begin
					act_ff[s] <= 1'b0;
					err2_ff[s] <= 1'b0;
					if (wr_ff[s]) begin
						last_wdata[s] <= s_hwdata[s];
					end
				end
			end
		end
	end

	// Outside a read's last cycle and the error cycle before it the data lines show the inverse, never a stale copy.
	always_comb begin
		for (int s = 0; s < NS; s++) begin
			fin[s] = act_ff[s] && (cnt_ff[s] == 4'h0);
			s_hresp[s] = fin[s] && err_en[s];
			s_hreadyout[s] = !act_ff[s] || (fin[s] && (!err_en[s] || err2_ff[s]));
			s_hrdata[s] = {1'b1, 3'(s), adr_ff[s][27:0]} ^ {DW{!(fin[s] && !wr_ff[s])}};
		end
	end
endmodule

// ---- test/ahbm_matrix_test.sv ----
// Self-checking bench of the bus matrix: routing, waits, errors, contention and reset.
`timescale 1ns/1ps
module ahbm_matrix_test import ahbm_pkg::*;;
	typedef struct packed {
		logic [MW-1:0] m;
		logic [AW-1:0] a;
		logic w;
		logic [SW-1:0] s;
	} ahbm_row_t;
	localparam ahbm_row_t ROWS [16] = '{
		'{M_IFETCH, 32'h0000_0100, 1'b0, S_FLASH_I},
		'{M_IFETCH, 32'h1fff_fffc, 1'b0, S_FLASH_I},
		'{M_CDATA, 32'h0000_0200, 1'b1, S_FLASH_D},
		'{M_DMA_A, 32'h0800_0000, 1'b1, S_FLASH_D},
		'{M_DMA_B, 32'h1000_0000, 1'b0, S_FLASH_D},
		'{M_CSYS, 32'h0000_0000, 1'b0, S_NONE},
		'{M_IFETCH, 32'h2000_0000, 1'b0, S_SRAM},
		'{M_CDATA, 32'h3fff_fffc, 1'b1, S_SRAM},
		'{M_IFETCH, 32'h6000_0000, 1'b0, S_EXTMEM},
		'{M_CSYS, 32'h6fff_fffc, 1'b1, S_EXTMEM},
		'{M_DMA_B, 32'h7000_0000, 1'b0, S_NONE},
		'{M_CSYS, 32'h4000_03fc, 1'b0, S_PLOW},
		'{M_DMA_A, 32'h4001_0400, 1'b1, S_PHIGH},
		'{M_DMA_B, 32'h4002_3000, 1'b0, S_AHBP},
		'{M_IFETCH, 32'h4000_0000, 1'b0, S_NONE},
		'{M_CDATA, 32'h5000_0000, 1'b1, S_NONE}
	};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [NM-1:0][AW-1:0] m_haddr = '0;
	logic [NM-1:0][1:0] m_htrans = '0;
	logic [NM-1:0] m_hwrite = '0;
	logic [NM-1:0][2:0] m_hsize = {NM{3'h2}};
	logic [NM-1:0][3:0] m_hprot = {NM{4'h3}};
	logic [NM-1:0][DW-1:0] m_hwdata = '0;
	logic [NM-1:0] m_hready;
	logic [NM-1:0] m_hresp;
	logic [NM-1:0][DW-1:0] m_hrdata;
	logic [NS-1:0] s_hsel;
	logic [NS-1:0][AW-1:0] s_haddr;
	logic [NS-1:0][1:0] s_htrans;
	logic [NS-1:0] s_hwrite;
	logic [NS-1:0][2:0] s_hsize;
	logic [NS-1:0][3:0] s_hprot;
	logic [NS-1:0][DW-1:0] s_hwdata;
	logic [NS-1:0] s_hready;
	logic [NS-1:0] s_hreadyout;
	logic [NS-1:0] s_hresp;
	logic [NS-1:0][DW-1:0] s_hrdata;
	logic plow_pclk_en;
	logic phigh_pclk_en;
	logic [3:0] slv_wait = 4'h0;
	logic [NS-1:0] slv_err = '0;
	logic [NS-1:0][7:0] hits;
	logic [NS-1:0][DW-1:0] last_wdata;
	logic [NM-1:0][AW-1:0] q_addr = '0;
	logic [NM-1:0][DW-1:0] q_wdata = '0;
	logic [NM-1:0] q_wr = '0;
	logic [NM-1:0] q_go = '0;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	int k;
	int k0;
	int w;

	ahbm_matrix uut (.clk_sys, .rst, .m_haddr, .m_htrans, .m_hwrite, .m_hsize, .m_hprot,
		.m_hwdata, .m_hready, .m_hresp, .m_hrdata, .s_hsel, .s_haddr, .s_htrans, .s_hwrite,
		.s_hsize, .s_hprot, .s_hwdata, .s_hready, .s_hreadyout, .s_hresp, .s_hrdata,
		.plow_pclk_en, .phigh_pclk_en);
	ahbm_slave_model slaves (.clk_sys, .rst, .s_hsel, .s_haddr, .s_hwrite, .s_hwdata,
		.s_hready, .s_hreadyout, .s_hresp, .s_hrdata, .wait_cnt(slv_wait), .err_en(slv_err),
		.hits, .last_wdata);

	always #12.5 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// Master drivers and checks
	// ------------------------------------------------------------
	for (genvar g = 0; g < NM; g++) begin : g_drv
		always @(posedge clk_sys) begin
			m_htrans[g] <= q_go[g] ? HT_NONSEQ : HT_IDLE;
			if (q_go[g]) begin
				m_haddr[g] <= q_addr[g];
				m_hwrite[g] <= q_wr[g];
			end
			if (m_htrans[g] == HT_NONSEQ && !q_go[g]) begin
				m_hwdata[g] <= q_wdata[g];
			end
		end
	end

	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// One single transfer; k counts cycles from the taking edge to completion.
	task automatic xfer(input int m, input logic [31:0] a, input logic wr, input logic [31:0] d,
		output logic r, output logic [31:0] rd, output int k);
		@(negedge clk_sys);
		q_addr[m] = a;
		q_wr[m] = wr;
		q_wdata[m] = d;
		q_go[m] = 1'b1;
		@(negedge clk_sys);
		q_go[m] = 1'b0;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while (m_hready[m] !== 1'b1 && k < 200);
		r = m_hresp[m];
		rd = m_hrdata[m];
		@(posedge clk_sys);
	endtask

	task automatic run_one(input int m, input logic [31:0] a, input logic wr,
		input logic [2:0] s, output int k);
		logic r;
		logic e;
		logic [31:0] rd;
		logic [31:0] d;
		logic [NS-1:0][7:0] h0;
		d = a ^ 32'h5a5a_a5a5;
		h0 = hits;
		xfer(m, a, wr, d, r, rd, k);
		@(negedge clk_sys);
		e = (s == S_NONE) ? 1'b1 : slv_err[s];
		chk_bit(r, e);
		chk_bit(k < 200, 1'b1);
		chk_bit(plow_pclk_en & phigh_pclk_en, 1'b1);
		if (!wr && !e) begin
			chk_word(rd, {1'b1, s, a[27:0]});
		end
		if (wr && !e) begin
			chk_word(last_wdata[s], d);
		end
		for (int i = 0; i < NS; i++) begin
			chk_word(32'(hits[i]), 32'(h0[i]) + 32'(i == int'(s)));
		end
	endtask

	task automatic contend(output int w);
		logic r2, r3, r4;
		logic [31:0] d2, d3, d4;
		int a2, a3, a4;
		fork
			xfer(M_CSYS, 32'h2000_0200, 1'b0, 32'h0, r2, d2, a2);
			xfer(M_DMA_A, 32'h2000_0204, 1'b0, 32'h0, r3, d3, a3);
			xfer(M_DMA_B, 32'h2000_0208, 1'b0, 32'h0, r4, d4, a4);
		join
		chk_word(d2, {1'b1, S_SRAM, 28'h000_0200});
		chk_word(d3, {1'b1, S_SRAM, 28'h000_0204});
		chk_word(d4, {1'b1, S_SRAM, 28'h000_0208});
		chk_bit(r2 | r3 | r4, 1'b0);
		chk_bit(a2 != a3 && a3 != a4 && a2 != a4, 1'b1);
		chk_bit(a2 < 200 && a3 < 200 && a4 < 200, 1'b1);
		w = (a2 < a3 && a2 < a4) ? 2 : ((a3 < a4) ? 3 : 4);
	endtask

	task automatic par_paths();
		logic r1, r2;
		logic [31:0] d1, d2;
		int a1, a2;
		fork
			xfer(M_IFETCH, 32'h0000_0400, 1'b0, 32'h0, r1, d1, a1);
			xfer(M_DMA_B, 32'h6000_0400, 1'b0, 32'h0, r2, d2, a2);
		join
		chk_word(32'(a1), 32'(k0));
		chk_word(32'(a2), 32'(k0));
		chk_word(d2, {1'b1, S_EXTMEM, 28'h000_0400});
		chk_word(d1, {1'b1, S_FLASH_I, 28'h000_0400});
		chk_bit(r1 | r2, 1'b0);
	endtask

	task automatic rst_view();
		chk_word(32'(m_hready), 32'h1f);
		chk_word(32'(m_hresp), 32'h0);
		chk_word(32'(s_hsel), 32'h0);
		chk_word(32'(s_hready), 32'h7f);
		chk_bit(plow_pclk_en & phigh_pclk_en, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	// Every slave address phase must carry NONSEQ and the master's size and protection.
	always @(negedge clk_sys) begin
		for (int i = 0; i < NS; i++) begin
			if (s_hsel[i] === 1'b1) begin
				chk_word(32'(s_htrans[i]), 32'(HT_NONSEQ));
				chk_word(32'({s_hsize[i], s_hprot[i]}), 32'h23);
			end
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		@(negedge clk_sys);
		rst_view();
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (ROWS[i]) begin
			run_one(ROWS[i].m, ROWS[i].a, ROWS[i].w, ROWS[i].s, k);
		end
		run_one(M_DMA_A, 32'h2000_0040, 1'b0, S_SRAM, k0);
		chk_word(32'(k0), 32'h4);
		par_paths();
		@(posedge clk_sys);
		slv_wait <= 4'h3;
		run_one(M_DMA_A, 32'h2000_0044, 1'b1, S_SRAM, k);
		chk_word(32'(k), 32'(k0 + 3));
		@(posedge clk_sys);
		slv_wait <= 4'h0;
		slv_err[S_SRAM] <= 1'b1;
		run_one(M_CDATA, 32'h2000_0080, 1'b1, S_SRAM, k);
		@(posedge clk_sys);
		slv_err <= '0;
		run_one(M_CSYS, 32'h2000_0100, 1'b0, S_SRAM, k);
		contend(w);
		chk_word(32'(w), 32'h3);
		run_one(M_DMA_A, 32'h2000_0104, 1'b0, S_SRAM, k);
		contend(w);
		chk_word(32'(w), 32'h4);
		@(negedge clk_sys);
		q_addr[M_CSYS] = 32'h2000_0300;
		q_go[M_CSYS] = 1'b1;
		@(negedge clk_sys);
		q_go[M_CSYS] = 1'b0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b1;
		@(negedge clk_sys);
		rst_view();
		@(posedge clk_sys);
		rst <= 1'b0;
		run_one(M_CSYS, 32'h2000_0300, 1'b0, S_SRAM, k);
		complete_run();
	end
endmodule
